/* File: rtl/adh_ctrl.sv */
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - wait at least 50 us after power-up before any serial traffic
// - link runs mode 1: clock idles low, data sampled on falling edge
// - falling edge of result_ready_n marks a new result to fetch
// - after lowering chip select wait setup delay before first clock edge
// - send reset byte 06h first to put device in default state
// - after reset wait 50 us plus 32 device clocks before next command
// - write config with 43h followed by four configuration bytes
// - optional readback of all config registers with 23h
// - wait hold delay after last clock before raising chip select
// - read a result with 16 clock rising edges under chip select
// - default image selects gain 16, continuous mode, 50/60 Hz rejection
// - average shorted readings as offset, subtract from later results
// - host alternates sensor and temperature readings itself
module adh_ctrl #(
  parameter int PWRUP_CYC_P = adh_pkg::PWRUP_CYC,
  parameter int RST_WAIT_CYC_P = adh_pkg::RST_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic chip_sel_n,
  output logic sclk,
  output logic mosi,
  input wire logic serial_out_ready_combined,
  input wire logic result_ready_n
);
  typedef enum logic [3:0] {
    ST_OFF, ST_PWRUP, ST_SETUP, ST_RST_SEND, ST_RST_WAIT, ST_CFG_SEND, ST_RB_SEND, ST_GO_SEND,
    ST_HOLD, ST_RUN, ST_RD_SETUP, ST_RD_SHIFT, ST_RD_HOLD, ST_PD_SETUP, ST_PD_SEND, ST_PD_HOLD
  } adh_state_t;

  typedef struct packed {
    adh_state_t state;
    logic [15:0] cnt;
    logic [2:0] idx;
    logic kick;
    logic sel;
    logic r1;
    logic r2;
    logic r3;
    logic rb_en;
    logic cal_en;
    logic ts_en;
    logic [31:0] cfg;
    logic [31:0] rb;
    logic rb_ok;
    logic [7:0] hi;
    logic [15:0] raw;
    logic [15:0] cor;
    logic [15:0] ofs;
    logic [18:0] sum;
    logic [2:0] calc;
    logic cal_act;
    logic cal_done;
    logic [31:0] rdata;
  } adh_ctrl_st_t;

  adh_ctrl_st_t st_q;
  adh_ctrl_st_t st_d;
  logic spi_start;
  logic [7:0] spi_tx;
  logic spi_done;
  logic [7:0] spi_rx;
  logic result_ready_n_fall;
  logic go_req;
  logic sleep_req;
  logic [31:0] word;
  logic [15:0] raw_new;
  logic [18:0] sum_new;

  function automatic logic [31:0] cfg_word(input logic [31:0] c, input logic cal, input logic ts);
    logic [31:0] w;
    w = c;
    if (cal) begin
      w[adh_pkg::MUX_LSB +: 4] = adh_pkg::MUX_SHORT;
    end
    if (ts) begin
      w[adh_pkg::TS_BIT] = 1'b1;
    end
    return w;
  endfunction

  function automatic logic [7:0] byte_at(input logic [31:0] w, input logic [2:0] i);
    return w[{i[1:0], 3'b000} +: 8];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  adh_shift u_shift (
    .clk(clk),
    .rst_b(rst_b),
    .start(spi_start),
    .tx(spi_tx),
    .miso(serial_out_ready_combined),
    .sclk(sclk),
    .mosi(mosi),
    .done(spi_done),
    .rx(spi_rx)
  );

  assign spi_start = st_q.kick;
  assign chip_sel_n = ~st_q.sel;
  assign rdata = st_q.rdata;
  assign result_ready_n_fall = st_q.r3 & ~st_q.r2;
  assign go_req = wr_stb && addr == adh_pkg::A_CTRL && wdata[adh_pkg::C_GO];
  assign sleep_req = wr_stb && addr == adh_pkg::A_CTRL && wdata[adh_pkg::C_SLEEP];
  assign word = cfg_word(st_q.cfg, st_q.cal_en, st_q.ts_en);
  assign raw_new = {st_q.hi, spi_rx};
  assign sum_new = st_q.sum + {{3{raw_new[15]}}, raw_new};

  always_comb begin
    case (st_q.state)
      ST_RST_SEND: spi_tx = adh_pkg::CMD_RESET;
      ST_CFG_SEND: spi_tx = (st_q.idx == 3'h0) ? adh_pkg::CMD_REG_WRITE : byte_at(word, 3'(st_q.idx - 3'h1));
      ST_RB_SEND: spi_tx = (st_q.idx == 3'h0) ? adh_pkg::CMD_REG_READ : adh_pkg::CMD_NOP;
      ST_GO_SEND: spi_tx = adh_pkg::CMD_START;
      ST_PD_SEND: spi_tx = adh_pkg::CMD_SLEEP;
      default: spi_tx = adh_pkg::CMD_NOP;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.kick = 1'b0;
    st_d.r1 = result_ready_n;
    st_d.r2 = st_q.r1;
    st_d.r3 = st_q.r2;
    st_d.cnt = (st_q.cnt != 16'h0) ? st_q.cnt - 16'h1 : 16'h0;
    if (wr_stb && addr == adh_pkg::A_CTRL) begin
      st_d.rb_en = wdata[adh_pkg::C_RB];
      st_d.cal_en = wdata[adh_pkg::C_CAL];
      st_d.ts_en = wdata[adh_pkg::C_TS];
    end
    if (wr_stb && addr == adh_pkg::A_CFG) begin
      st_d.cfg = wdata;
    end
    case (st_q.state)
      ST_OFF: begin
        if (go_req) begin
          st_d.state = ST_PWRUP;
          st_d.cnt = 16'(PWRUP_CYC_P - 1);
          st_d.cal_act = wdata[adh_pkg::C_CAL];
          st_d.cal_done = 1'b0;
          st_d.calc = 3'h0;
          st_d.sum = 19'h0;
          st_d.rb_ok = 1'b0;
        end
      end
      ST_PWRUP: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_SETUP;
          st_d.sel = 1'b1;
          st_d.cnt = adh_pkg::CSSC_CYC - 16'h1;
        end
      end
      ST_SETUP: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_RST_SEND;
          st_d.kick = 1'b1;
        end
      end
      ST_RST_SEND: begin
        if (spi_done) begin
          st_d.state = ST_RST_WAIT;
          st_d.cnt = 16'(RST_WAIT_CYC_P - 1);
        end
      end
      ST_RST_WAIT: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_CFG_SEND;
          st_d.idx = 3'h0;
          st_d.kick = 1'b1;
        end
      end
      ST_CFG_SEND: begin
        if (spi_done) begin
          st_d.kick = 1'b1;
          st_d.idx = st_q.idx + 3'h1;
          if (st_q.idx == 3'h4) begin
            st_d.idx = 3'h0;
            st_d.state = st_q.rb_en ? ST_RB_SEND : ST_GO_SEND;
          end
        end
      end
      ST_RB_SEND: begin
        if (spi_done) begin
          st_d.kick = 1'b1;
          st_d.idx = st_q.idx + 3'h1;
          if (st_q.idx != 3'h0) begin
            st_d.rb[{st_q.idx[1:0] - 2'h1, 3'b000} +: 8] = spi_rx;
          end
          if (st_q.idx == 3'h4) begin
            st_d.rb_ok = ({spi_rx, st_q.rb[23:0]} == word);
            st_d.state = ST_GO_SEND;
          end
        end
      end
      ST_GO_SEND: begin
        if (spi_done) begin
          st_d.state = ST_HOLD;
          st_d.cnt = adh_pkg::SCCS_CYC - 16'h1;
        end
      end
      ST_HOLD: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_RUN;
          st_d.sel = 1'b0;
        end
      end
      ST_RUN: begin
        // sleep wins over a result that is ready in the same cycle
        if (sleep_req) begin
          st_d.state = ST_PD_SETUP;
          st_d.sel = 1'b1;
          st_d.cnt = adh_pkg::CSSC_CYC - 16'h1;
        end else if (result_ready_n_fall) begin
          st_d.state = ST_RD_SETUP;
          st_d.sel = 1'b1;
          st_d.cnt = adh_pkg::CSSC_CYC - 16'h1;
        end
      end
      ST_RD_SETUP: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_RD_SHIFT;
          st_d.idx = 3'h0;
          st_d.kick = 1'b1;
        end
      end
      ST_RD_SHIFT: begin
        if (spi_done) begin
          if (st_q.idx == 3'h0) begin
            st_d.hi = spi_rx;
            st_d.idx = 3'h1;
            st_d.kick = 1'b1;
          end else begin
            st_d.raw = raw_new;
            st_d.cor = raw_new - st_q.ofs;
            st_d.state = ST_RD_HOLD;
            st_d.cnt = adh_pkg::SCCS_CYC - 16'h1;
            if (st_q.cal_act) begin
              st_d.sum = sum_new;
              st_d.calc = st_q.calc + 3'h1;
              if (st_q.calc == adh_pkg::CAL_LAST) begin
                st_d.ofs = sum_new[adh_pkg::CAL_SHIFT +: 16];
                st_d.cal_act = 1'b0;
                st_d.cal_done = 1'b1;
              end
            end
          end
        end
      end
      ST_RD_HOLD: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_RUN;
          st_d.sel = 1'b0;
        end
      end
      ST_PD_SETUP: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_PD_SEND;
          st_d.kick = 1'b1;
        end
      end
      ST_PD_SEND: begin
        if (spi_done) begin
          st_d.state = ST_PD_HOLD;
          st_d.cnt = adh_pkg::SCCS_CYC - 16'h1;
        end
      end
      ST_PD_HOLD: begin
        if (st_q.cnt == 16'h0) begin
          st_d.state = ST_OFF;
          st_d.sel = 1'b0;
        end
      end
      default: st_d.state = ST_OFF;
    endcase
    st_d.rdata = 32'h0;
    if (rd_stb) begin
      case (addr)
        adh_pkg::A_CTRL: st_d.rdata = {27'h0, st_q.ts_en, st_q.cal_en, st_q.rb_en, 2'b00};
        adh_pkg::A_CFG: st_d.rdata = st_q.cfg;
        adh_pkg::A_STAT: st_d.rdata = {23'h0, st_q.state, st_q.cal_act, st_q.rb_ok, st_q.cal_done,
          st_q.state inside {ST_RUN, ST_RD_SETUP, ST_RD_SHIFT, ST_RD_HOLD},
          !(st_q.state inside {ST_OFF, ST_RUN})};
        adh_pkg::A_RAW: st_d.rdata = {16'h0, st_q.raw};
        adh_pkg::A_COR: st_d.rdata = {16'h0, st_q.cor};
        adh_pkg::A_OFS: st_d.rdata = {16'h0, st_q.ofs};
        adh_pkg::A_RB: st_d.rdata = st_q.rb;
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.cfg <= adh_pkg::CFG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // helper counters watched only by the checks below
  logic sclk_prev;
  logic [7:0] cs_low_cnt;
  logic [7:0] since_fall;
  logic [4:0] rise_cnt;
  logic [15:0] dwell;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev <= 1'b0;
      cs_low_cnt <= 8'h0;
      since_fall <= 8'hFF;
      rise_cnt <= 5'h0;
      dwell <= 16'h0;
    end else begin
      sclk_prev <= sclk;
      cs_low_cnt <= chip_sel_n ? 8'h0 : ((cs_low_cnt == 8'hFF) ? cs_low_cnt : cs_low_cnt + 8'h1);
      since_fall <= (sclk_prev && !sclk) ? 8'h0 : ((since_fall == 8'hFF) ? since_fall : since_fall + 8'h1);
      rise_cnt <= chip_sel_n ? 5'h0 : ((sclk && !sclk_prev) ? rise_cnt + 5'h1 : rise_cnt);
      dwell <= (st_q.state inside {ST_PWRUP, ST_RST_WAIT}) ? dwell + 16'h1 : 16'h0;
    end
  end

  property p_pwrup_wait;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_PWRUP) ##1 (st_q.state == ST_SETUP) |-> dwell >= PWRUP_CYC_P;
  endproperty
  a_pwrup_wait: assert property (p_pwrup_wait) else $error("link used before power-up wait");

  property p_idle_low;
    @(posedge clk) disable iff (!rst_b) chip_sel_n |-> !sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial clock high while deselected");

  property p_ready_fetch;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_RUN && result_ready_n_fall) |=> !chip_sel_n && (st_q.state inside {ST_RD_SETUP, ST_PD_SETUP});
  endproperty
  a_ready_fetch: assert property (p_ready_fetch) else $error("ready edge not answered");

  property p_cs_setup;
    @(posedge clk) disable iff (!rst_b) (sclk && !sclk_prev) |-> cs_low_cnt >= adh_pkg::CSSC_CYC;
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("clock edge too soon after select");

  property p_reset_first;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_SETUP && st_q.cnt == 16'h0) |=> spi_start && spi_tx == adh_pkg::CMD_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("first byte is not reset");

  property p_reset_wait;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_RST_WAIT) ##1 (st_q.state == ST_CFG_SEND) |-> dwell >= RST_WAIT_CYC_P;
  endproperty
  a_reset_wait: assert property (p_reset_wait) else $error("reset wait too short");

  property p_cfg_cmd;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_RST_WAIT && st_q.cnt == 16'h0) |=> spi_start && spi_tx == adh_pkg::CMD_REG_WRITE;
  endproperty
  a_cfg_cmd: assert property (p_cfg_cmd) else $error("config write byte wrong");

  property p_rb_cmd;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_CFG_SEND && spi_done && st_q.idx == 3'h4 && st_q.rb_en)
      |=> spi_start && spi_tx == adh_pkg::CMD_REG_READ;
  endproperty
  a_rb_cmd: assert property (p_rb_cmd) else $error("readback byte wrong");

  property p_cs_hold;
    @(posedge clk) disable iff (!rst_b) $rose(chip_sel_n) |-> since_fall >= adh_pkg::SCCS_CYC;
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("deselect too soon after clock");

  property p_read_16;
    @(posedge clk) disable iff (!rst_b)
    ($rose(chip_sel_n) && $past(st_q.state) == ST_RD_HOLD) |-> rise_cnt == 5'd16;
  endproperty
  a_read_16: assert property (p_read_16) else $error("result read is not 16 clocks");

  property p_sleep_cmd;
    @(posedge clk) disable iff (!rst_b)
    (st_q.state == ST_RUN && sleep_req) |-> ##14 (spi_start && spi_tx == adh_pkg::CMD_SLEEP);
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep byte not sent");

  c_running: cover property (@(posedge clk) disable iff (!rst_b) st_q.state == ST_HOLD ##1 st_q.state == ST_RUN);
  c_result: cover property (@(posedge clk) disable iff (!rst_b) st_q.state == ST_RD_SHIFT && spi_done && st_q.idx == 3'h1);
  c_sleep: cover property (@(posedge clk) disable iff (!rst_b) st_q.state == ST_PD_HOLD ##1 st_q.state == ST_OFF);
  c_cal: cover property (@(posedge clk) disable iff (!rst_b) $rose(st_q.cal_done));
endmodule
`default_nettype wire

/* File: shared/adh_pkg.sv */
`default_nettype none
package adh_pkg;
  // clock and link timing
  localparam int CLK_NS = 4;
  localparam int PWRUP_NS = 50000;
  localparam int RST_BASE_NS = 50000;
  localparam int RST_DEVCLK_N = 32;
  localparam int DEVCLK_NS = 244;
  localparam int CSSC_NS = 50;
  localparam int SCCS_NS = 50;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_WAIT_CYC = (RST_BASE_NS + RST_DEVCLK_N * DEVCLK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] CSSC_CYC = 16'((CSSC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] SCCS_CYC = 16'((SCCS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SCLK_HALF = 4'h8;
  // command bytes
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [7:0] CMD_REG_WRITE = 8'h43;
  localparam logic [7:0] CMD_REG_READ = 8'h23;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [7:0] CMD_NOP = 8'h00;
  // configuration image, byte 0 sent first
  localparam logic [31:0] CFG_RST = 32'h0010_0408;
  localparam int MUX_LSB = 4;
  localparam logic [3:0] MUX_SHORT = 4'hE;
  localparam int TS_BIT = 9;
  localparam logic [2:0] CAL_LAST = 3'h7;
  localparam int CAL_SHIFT = 3;
  // register map of the controller
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_RAW = 8'h0C;
  localparam logic [7:0] A_COR = 8'h10;
  localparam logic [7:0] A_OFS = 8'h14;
  localparam logic [7:0] A_RB = 8'h18;
  localparam int C_GO = 0;
  localparam int C_SLEEP = 1;
  localparam int C_RB = 2;
  localparam int C_CAL = 3;
  localparam int C_TS = 4;
endpackage
`default_nettype wire

/* File: rtl/adh_shift.sv */
`timescale 1ns/1ns
`default_nettype none
module adh_shift (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] tx,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic done,
  output logic [7:0] rx
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic busy;
    logic sclk;
    logic mosi;
    logic done;
    logic [3:0] div;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [7:0] rx;
  } adh_shift_st_t;

  adh_shift_st_t q;
  adh_shift_st_t d;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.s1 = miso;
    d.s2 = q.s1;
    d.done = 1'b0;
    if (!q.busy) begin
      if (start) begin
        d.busy = 1'b1;
        d.sh = tx;
        d.bitn = 3'h0;
        d.div = adh_pkg::SCLK_HALF - 4'h1;
      end
    end else if (q.div != 4'h0) begin
      d.div = q.div - 4'h1;
    end else begin
      d.div = adh_pkg::SCLK_HALF - 4'h1;
      if (!q.sclk) begin
        // mode 1: drive on the rising edge, msb first
        d.sclk = 1'b1;
        d.mosi = q.sh[7];
      end else begin
        // sample on the falling edge, well after the device drove
        d.sclk = 1'b0;
        d.rx = {q.rx[6:0], q.s2};
        d.sh = {q.sh[6:0], 1'b0};
        d.bitn = q.bitn + 3'h1;
        if (q.bitn == 3'h7) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sclk = q.sclk;
  assign mosi = q.mosi;
  assign done = q.done;
  assign rx = q.rx;
endmodule
`default_nettype wire

/* File: dv/adh_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module adh_dev_model #(
  parameter int PER_NS = 4000,
  parameter int RST_NS = 240,
  parameter logic [15:0] FIRST = 16'hA53C,
  parameter logic [15:0] STEP = 16'h0101,
  parameter logic [15:0] OFS_A = 16'hFFF7,
  parameter logic [15:0] OFS_B = 16'hFFF5,
  parameter logic [15:0] TEMP_V = 16'h0C80
) (
  input wire logic chip_sel_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic serial_out_ready_combined,
  output logic result_ready_n
);
  logic [31:0] cfg_q = 32'h0000_0000;
  logic [31:0] tx_q = 32'h0000_0000;
  logic [7:0] rx_q = 8'h00;
  logic [15:0] res_q = 16'h0000;
  logic run_q = 1'b0;
  int nbit = 0;
  int ntx = 0;
  int wr_left = 0;
  int idx = 0;
  int rst_seen = 0;
  int faults = 0;
  realtime t_cs = 0.0;
  realtime t_fall = 0.0;
  realtime t_rst = -1.0e9;
  realtime t_next = 0.0;
  initial begin
    result_ready_n = 1'b1;
    serial_out_ready_combined = 1'b0;
  end
  //////////////////////////////
  always @(negedge chip_sel_n) begin
    t_cs = $realtime;
    if (sclk !== 1'b0) faults++;
    if (result_ready_n == 1'b0) begin
      tx_q = {res_q, 16'h0000};
      ntx = 16;
    end
  end
  // frame end clears the bit, transmit and write counters; line no longer holds its value
  always @(posedge chip_sel_n) begin
    if (t_fall > t_cs && (sclk !== 1'b0 || $realtime - t_fall < adh_pkg::SCCS_NS)) faults++;
    nbit = 0;
    ntx = 0;
    wr_left = 0;
    serial_out_ready_combined = ~serial_out_ready_combined;
  end
  always @(posedge sclk) begin
    if (chip_sel_n === 1'b0) begin
      if ($realtime - t_cs < adh_pkg::CSSC_NS || $realtime - t_rst < RST_NS) faults++;
      result_ready_n = 1'b1;
      if (ntx > 0) begin
        serial_out_ready_combined = tx_q[31];
        tx_q = tx_q << 1;
        ntx--;
      end
    end
  end
  always @(negedge sclk) begin
    if (chip_sel_n === 1'b0) begin
      t_fall = $realtime;
      rx_q = {rx_q[6:0], mosi};
      nbit++;
      if (nbit == 8) begin
        nbit = 0;
        if (wr_left > 0) begin
          cfg_q = {rx_q, cfg_q[31:8]};
          wr_left--;
        end else if (ntx == 0) begin
          case (rx_q)
            adh_pkg::CMD_RESET: begin
              cfg_q = 32'h0000_0000;
              run_q = 1'b0;
              rst_seen++;
              t_rst = $realtime;
            end
            adh_pkg::CMD_REG_WRITE: wr_left = 4;
            adh_pkg::CMD_REG_READ: begin
              tx_q = {cfg_q[7:0], cfg_q[15:8], cfg_q[23:16], cfg_q[31:24]};
              ntx = 32;
            end
            adh_pkg::CMD_START: begin
              run_q = 1'b1;
              idx = 0;
              t_next = $realtime + PER_NS;
            end
            adh_pkg::CMD_SLEEP: begin
              run_q = 1'b0;
              result_ready_n = 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end
  // conversions paced in real time, not by the host clock
  always begin
    #10;
    if (run_q && $realtime >= t_next) begin
      t_next = t_next + PER_NS;
      result_ready_n = 1'b1;
      #8;
      if (cfg_q[adh_pkg::TS_BIT]) res_q = TEMP_V;
      else if (cfg_q[adh_pkg::MUX_LSB +: 4] == adh_pkg::MUX_SHORT) res_q = idx[0] ? OFS_B : OFS_A;
      else res_q = 16'(FIRST + STEP * 16'(idx));
      idx++;
      result_ready_n = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/adh_ctrl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module adh_ctrl_tb_top;
  localparam int PWR = 40;
  localparam int RW = 60;
  localparam logic [15:0] FIRST = 16'hA53C;
  localparam logic [15:0] STEP = 16'h0101;
  localparam logic [15:0] OFS_A = 16'hFFF7;
  // mean of the alternating shorted readings FFF7 and FFF5
  localparam logic [15:0] OFS_AVG = 16'hFFF6;
  localparam logic [15:0] TEMP_V = 16'h0C80;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } adh_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic chip_sel_n;
  logic sclk;
  logic mosi;
  logic serial_out_ready_combined;
  logic result_ready_n;
  int fails = 0;
  int tests_run = 0;
  adh_row_t rows [10] = '{
    '{1'b0, adh_pkg::A_CFG, '0, 32'hFFFF_FFFF, adh_pkg::CFG_RST},
    '{1'b0, adh_pkg::A_CTRL, '0, 32'hFFFF_FFFF, '0},
    '{1'b0, adh_pkg::A_STAT, '0, 32'h0000_0003, '0},
    '{1'b1, adh_pkg::A_CFG, 32'hA5C3_0F1E, '0, '0},
    '{1'b0, adh_pkg::A_CFG, '0, 32'hFFFF_FFFF, 32'hA5C3_0F1E},
    '{1'b1, adh_pkg::A_CFG, adh_pkg::CFG_RST, '0, '0},
    '{1'b1, 8'h20, 32'hFFFF_FFFF, '0, '0},
    '{1'b0, 8'h20, '0, 32'hFFFF_FFFF, '0},
    '{1'b1, adh_pkg::A_CTRL, 32'h0000_001C, '0, '0},
    '{1'b0, adh_pkg::A_CTRL, '0, 32'h0000_001F, 32'h0000_001C}};
  always #2 clk = ~clk;
  adh_ctrl #(.PWRUP_CYC_P(PWR), .RST_WAIT_CYC_P(RW)) adh_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .chip_sel_n(chip_sel_n), .sclk(sclk), .mosi(mosi),
    .serial_out_ready_combined(serial_out_ready_combined), .result_ready_n(result_ready_n));
  adh_dev_model #(.RST_NS(RW * adh_pkg::CLK_NS), .FIRST(FIRST), .STEP(STEP), .OFS_A(OFS_A),
    .TEMP_V(TEMP_V)) adh_dev_model_inst (
    .chip_sel_n(chip_sel_n), .sclk(sclk), .mosi(mosi),
    .serial_out_ready_combined(serial_out_ready_combined), .result_ready_n(result_ready_n));
  //////////////////////////////
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // second edge keeps the strobe from being set and cleared in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic wait_sig(ref logic s, input logic lvl, output int n);
    n = 0;
    while (s !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) chk_bit(s, lvl);
  endtask
  task automatic wait_run(input logic want);
    logic [31:0] v;
    int k;
    k = 0;
    // wait for a settled state: running and idle, or fully off after the sleep frame
    rd(adh_pkg::A_STAT, v);
    while (v[1:0] !== {want, 1'b0} && k < 3000) begin
      rd(adh_pkg::A_STAT, v);
      k++;
    end
    chk_bit(v[1], want);
    chk_bit(v[0], 1'b0);
  endtask
  task automatic get_result(output logic [31:0] v);
    int n;
    wait_sig(result_ready_n, 1'b0, n);
    wait_sig(chip_sel_n, 1'b0, n);
    wait_sig(chip_sel_n, 1'b1, n);
    repeat (3) @(posedge clk);
    rd(adh_pkg::A_RAW, v);
  endtask
  //////////////////////////////
  initial begin
    #300000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    int n;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, d);
        chk_reg(d & rows[i].m, rows[i].e);
      end
    end
    wr(adh_pkg::A_CTRL, 32'h0000_0005);
    wait_sig(chip_sel_n, 1'b0, n);
    chk_bit(n >= PWR - 2, 1'b1);
    wait_run(1'b1);
    chk_reg(adh_dev_model_inst.cfg_q, adh_pkg::CFG_RST);
    chk_bit(adh_dev_model_inst.rst_seen == 1, 1'b1);
    chk_bit(adh_dev_model_inst.run_q, 1'b1);
    rd(adh_pkg::A_RB, d);
    chk_reg(d, adh_pkg::CFG_RST);
    rd(adh_pkg::A_STAT, d);
    chk_bit(d[3], 1'b1);
    for (int i = 0; i < 3; i++) begin
      get_result(d);
      chk_reg(d & 32'h0000_FFFF, {16'h0000, 16'(FIRST + STEP * 16'(i))});
    end
    wr(adh_pkg::A_CTRL, 32'h0000_0002);
    wait_run(1'b0);
    chk_bit(adh_dev_model_inst.run_q, 1'b0);
    wr(adh_pkg::A_CTRL, 32'h0000_0009);
    wait_run(1'b1);
    chk_bit(adh_dev_model_inst.cfg_q[adh_pkg::MUX_LSB +: 4] == adh_pkg::MUX_SHORT, 1'b1);
    repeat (9) get_result(d);
    chk_reg(d & 32'h0000_FFFF, {16'h0000, OFS_A});
    rd(adh_pkg::A_STAT, d);
    chk_bit(d[2], 1'b1);
    rd(adh_pkg::A_OFS, d);
    chk_reg(d & 32'h0000_FFFF, {16'h0000, OFS_AVG});
    rd(adh_pkg::A_COR, d);
    chk_reg(d & 32'h0000_FFFF, {16'h0000, 16'(OFS_A - OFS_AVG)});
    wr(adh_pkg::A_CTRL, 32'h0000_0002);
    wait_run(1'b0);
    wr(adh_pkg::A_CTRL, 32'h0000_0011);
    wait_run(1'b1);
    chk_bit(adh_dev_model_inst.cfg_q[adh_pkg::TS_BIT], 1'b1);
    get_result(d);
    chk_reg(d & 32'h0000_FFFF, {16'h0000, TEMP_V});
    chk_bit(adh_dev_model_inst.faults == 0, 1'b1);
    // reset in the middle of a result readout
    wait_sig(chip_sel_n, 1'b0, n);
    repeat (40) @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk_bit(chip_sel_n, 1'b1);
    chk_bit(sclk, 1'b0);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(adh_pkg::A_STAT, d);
    chk_reg(d & 32'h0000_0003, 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
